// ### logic/pattern_loop_defs.vh
`ifndef PATTERN_LOOP_DEFS_VH
`define PATTERN_LOOP_DEFS_VH

// register indices within one channel; byte address is four times the index
`define IDX_PAT_LO        6'h12
`define IDX_PAT_MID       6'h13
`define IDX_PAT_HIGH      6'h14
`define IDX_CODE_LENGTHS  6'h15
`define IDX_GEN_CODE      6'h16
`define IDX_ACT_CODE      6'h17
`define IDX_DEACT_CODE    6'h18
`define IDX_STATUS        6'h1e
`define IDX_CONTROL       6'h1f

// channel placement: ch1..16 at 0x000 + 0x040 * (n-1), ch0 in the 0x7c0 block
`define CH_STRIDE_IDX     11'h040
`define CH0_BLOCK         5'h1f
`define NUM_CH            17

// reset values
`define RST_PAT           8'h55
`define RST_CODE_LENGTHS  6'h01
`define RST_GEN_CODE      8'h01
`define RST_ACT_CODE      8'h01
`define RST_DEACT_CODE    8'h09
`define RST_CONTROL       3'h0

// loop_code_lengths fields
`define LEN_GEN_HI        5
`define LEN_GEN_LO        4
`define LEN_ACT_HI        3
`define LEN_ACT_LO        2
`define LEN_DEACT_HI      1
`define LEN_DEACT_LO      0

// control fields
`define CTL_SEL_HI        1
`define CTL_SEL_LO        0
`define CTL_AUTO_LOOP     2

// pattern_generate_select codes
`define SEL_OFF           2'h0
`define SEL_PRBS          2'h1
`define SEL_PAT           2'h2
`define SEL_CODE          2'h3

// timing
`define PCLK_MHZ          125
`define LOOP_HOLD_MS      5100
`define LOOP_HOLD_CYCLES  (`LOOP_HOLD_MS * 1000 * `PCLK_MHZ)

`endif

// ### logic/pattern_gen.v
`timescale 1ns/100ps
`include "pattern_loop_defs.vh"

module pattern_gen (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // configuration
    input  wire [1:0]  pattern_generate_select,
    input  wire [23:0] arbitrary_pattern,
    input  wire [7:0]  inband_loop_code,
    input  wire [1:0]  generate_code_length,
    // line side
    input  wire        bit_en,
    output reg         gen_data_ff
);

    reg [1:0]  last_sel_ff;
    reg [4:0]  pos_ff;
    reg [14:0] prbs_ff;
    wire [4:0] code_top;

    assign code_top = {3'b000, generate_code_length} + 5'h04;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_sel_ff <= `SEL_OFF;
            pos_ff      <= 5'h00;
            prbs_ff     <= 15'h7fff;
            gen_data_ff <= 1'b0;
        end else if (pattern_generate_select != last_sel_ff) begin
            // restart the arbitrary pattern or loop code from its first bit; the prbs register keeps its state
            last_sel_ff <= pattern_generate_select;
            pos_ff      <= (pattern_generate_select == `SEL_PAT) ? 5'h17 : code_top;
            gen_data_ff <= 1'b0;
        end else if (bit_en) begin
            case (pattern_generate_select)
                `SEL_PRBS: begin
                    gen_data_ff <= prbs_ff[14];
                    prbs_ff     <= {prbs_ff[13:0], prbs_ff[14] ^ prbs_ff[13]};
                end
                `SEL_PAT: begin
                    gen_data_ff <= arbitrary_pattern[pos_ff];
                    pos_ff      <= (pos_ff == 5'h00) ? 5'h17 : pos_ff - 5'h01;
                end
                `SEL_CODE: begin
                    gen_data_ff <= inband_loop_code[pos_ff[2:0]];
                    // bit 0 closes each repetition, then the code restarts at once
                    pos_ff      <= (pos_ff == 5'h00) ? code_top : pos_ff - 5'h01;
                end
                default: begin
                    gen_data_ff <= 1'b0;
                end
            endcase
        end
    end

endmodule // pattern_gen

// ### logic/code_det.v
`timescale 1ns/100ps
`include "pattern_loop_defs.vh"

module code_det #(
    parameter [29:0] HOLD_CYCLES = `LOOP_HOLD_CYCLES
) (
    // clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // configuration
    input  wire [7:0] code_bits,
    input  wire [1:0] code_length,
    // line side
    input  wire       bit_en,
    input  wire       rx_data,
    // status
    output reg        present_ff,
    output reg        held_ff
);

    reg  [7:0]  window_ff;
    reg  [3:0]  gap_ff;
    reg  [29:0] timer_ff;
    wire [7:0]  nxt_window;
    wire [7:0]  mask;
    wire [3:0]  code_len_bits;
    wire        match;

    assign nxt_window    = {window_ff[6:0], rx_data};
    assign mask          = 8'hff >> (2'h3 - code_length);
    assign code_len_bits = {2'b00, code_length} + 4'h5;
    // newest received bit lines up with bit 0 of the code
    assign match         = ((nxt_window ^ code_bits) & mask) == 8'h00;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            window_ff  <= 8'h00;
            gap_ff     <= 4'h0;
            present_ff <= 1'b0;
        end else if (bit_en) begin
            window_ff <= nxt_window;
            if (match) begin
                gap_ff     <= 4'h0;
                present_ff <= 1'b1;
            end else if (gap_ff + 4'h1 >= code_len_bits) begin
                // a whole code period passed without an aligned match
                gap_ff     <= 4'h0;
                present_ff <= 1'b0;
            end else begin
                gap_ff <= gap_ff + 4'h1;
            end
        end
    end

    // held once the code has been present for more than the hold time
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_ff <= 30'h0;
            held_ff  <= 1'b0;
        end else if (!present_ff) begin
            timer_ff <= 30'h0;
            held_ff  <= 1'b0;
        end else if (timer_ff == HOLD_CYCLES) begin
            held_ff <= 1'b1;
        end else begin
            timer_ff <= timer_ff + 30'h1;
        end
    end

endmodule // code_det

// ### logic/pattern_loop_regs.v
`timescale 1ns/100ps
`include "pattern_loop_defs.vh"

// Summary of operation
// - arbitrary pattern: one 24-bit word, three bytes
// - pattern sent bit 23 first
// - pattern byte registers read/write, reset 0x55
// - bits 5-4 set generated code length 5..8
// - bits 3-2 set activate code length 5..8
// - bits 1-0 set deactivate length, default 6
// - generated code low bits, bit 0 last
// - code repeats back to back until disabled
// - activate code compared, bit 0 received last
// - deactivate code compared, bit 0 received last
// - length register reset 0x01, bits 7-6 reserved
// - generate and activate code registers reset 0x01
// - per-channel copies, 0x40 stride, channel 0 block
// - select: off, pseudo-random, arbitrary, loop code
// - auto loopback after code held over 5.1 s
module pattern_loop_regs #(
    parameter [29:0] HOLD_CYCLES = `LOOP_HOLD_CYCLES
) (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [12:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // per-channel line side, index 0 is channel 0
    input  wire [16:0] gen_bit_en,
    input  wire [16:0] det_bit_en,
    input  wire [16:0] det_data,
    output wire [16:0] gen_data,
    output reg  [16:0] loopback_active_ff
);

    reg  [7:0]  pat_lo_ff     [0:16];
    reg  [7:0]  pat_mid_ff    [0:16];
    reg  [7:0]  pat_high_ff   [0:16];
    reg  [5:0]  lengths_ff    [0:16];
    reg  [7:0]  gen_code_ff   [0:16];
    reg  [7:0]  act_code_ff   [0:16];
    reg  [7:0]  deact_code_ff [0:16];
    reg  [2:0]  control_ff    [0:16];

    wire [16:0] act_present;
    wire [16:0] act_held;
    wire [16:0] deact_present;
    wire [16:0] deact_held;

    wire [10:0] idx;
    wire [5:0]  reg_off;
    wire        is_ch0;
    wire        is_chn;
    reg  [4:0]  ch;
    reg         hit;
    reg  [7:0]  rd_byte;
    wire        access;
    wire        do_write;
    integer     i;

    // address decode
    assign idx      = paddr[12:2];
    assign reg_off  = idx[5:0];
    assign is_ch0   = (idx[10:6] == `CH0_BLOCK);
    assign is_chn   = (idx[10] == 1'b0);
    assign access   = psel & penable;
    assign do_write = access & pready & pwrite;

    always @* begin
        ch = 5'h00;
        if (is_chn) begin
            ch = {1'b0, idx[9:6]} + 5'h01;
        end
    end

    // which offsets exist; channel 0 lacks the low byte and the lengths
    always @* begin
        hit = 1'b0;
        if (is_chn || is_ch0) begin
            case (reg_off)
                `IDX_PAT_LO:       hit = is_chn;
                `IDX_CODE_LENGTHS: hit = is_chn;
                `IDX_PAT_MID:      hit = 1'b1;
                `IDX_PAT_HIGH:     hit = 1'b1;
                `IDX_GEN_CODE:     hit = 1'b1;
                `IDX_ACT_CODE:     hit = 1'b1;
                `IDX_DEACT_CODE:   hit = 1'b1;
                `IDX_STATUS:       hit = 1'b1;
                `IDX_CONTROL:      hit = 1'b1;
                default:           hit = 1'b0;
            endcase
        end
    end

    // read mux; narrow registers sit in the low bits
    always @* begin
        rd_byte = 8'h00;
        case (reg_off)
            `IDX_PAT_LO:       rd_byte = pat_lo_ff[ch];
            `IDX_PAT_MID:      rd_byte = pat_mid_ff[ch];
            `IDX_PAT_HIGH:     rd_byte = pat_high_ff[ch];
            `IDX_CODE_LENGTHS: rd_byte = {2'b00, lengths_ff[ch]};
            `IDX_GEN_CODE:     rd_byte = gen_code_ff[ch];
            `IDX_ACT_CODE:     rd_byte = act_code_ff[ch];
            `IDX_DEACT_CODE:   rd_byte = deact_code_ff[ch];
            `IDX_STATUS:       rd_byte = {3'b000, loopback_active_ff[ch], deact_held[ch], act_held[ch],
                                          deact_present[ch], act_present[ch]};
            `IDX_CONTROL:      rd_byte = {5'h00, control_ff[ch]};
            default:           rd_byte = 8'h00;
        endcase
    end

    // apb handshake: one wait state, answer registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else if (access && !pready) begin
            pready  <= 1'b1;
            pslverr <= ~hit;
            prdata  <= (hit && !pwrite) ? {24'h000000, rd_byte} : 32'h0;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end
    end

    // register writes take effect at the completing edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < `NUM_CH; i = i + 1) begin
                pat_lo_ff[i]     <= `RST_PAT;
                pat_mid_ff[i]    <= `RST_PAT;
                pat_high_ff[i]   <= `RST_PAT;
                lengths_ff[i]    <= `RST_CODE_LENGTHS;
                gen_code_ff[i]   <= `RST_GEN_CODE;
                act_code_ff[i]   <= `RST_ACT_CODE;
                deact_code_ff[i] <= `RST_DEACT_CODE;
                control_ff[i]    <= `RST_CONTROL;
            end
        end else if (do_write && hit) begin
            case (reg_off)
                `IDX_PAT_LO:       pat_lo_ff[ch]     <= pwdata[7:0];
                `IDX_PAT_MID:      pat_mid_ff[ch]    <= pwdata[7:0];
                `IDX_PAT_HIGH:     pat_high_ff[ch]   <= pwdata[7:0];
                `IDX_CODE_LENGTHS: lengths_ff[ch]    <= pwdata[5:0];
                `IDX_GEN_CODE:     gen_code_ff[ch]   <= pwdata[7:0];
                `IDX_ACT_CODE:     act_code_ff[ch]   <= pwdata[7:0];
                `IDX_DEACT_CODE:   deact_code_ff[ch] <= pwdata[7:0];
                `IDX_CONTROL:      control_ff[ch]    <= pwdata[2:0];
                default:           control_ff[ch]    <= control_ff[ch];
            endcase
        end
    end

    // one generator and two detectors per channel
    genvar g;
    generate
        for (g = 0; g < `NUM_CH; g = g + 1) begin : chan
            pattern_gen u_gen (
                .pclk                    (pclk),
                .presetn                 (presetn),
                .pattern_generate_select (control_ff[g][`CTL_SEL_HI:`CTL_SEL_LO]),
                .arbitrary_pattern       ({pat_high_ff[g], pat_mid_ff[g], pat_lo_ff[g]}),
                .inband_loop_code        (gen_code_ff[g]),
                .generate_code_length    (lengths_ff[g][`LEN_GEN_HI:`LEN_GEN_LO]),
                .bit_en                  (gen_bit_en[g]),
                .gen_data_ff             (gen_data[g])
            );

            code_det #(
                .HOLD_CYCLES (HOLD_CYCLES)
            ) u_act (
                .pclk        (pclk),
                .presetn     (presetn),
                .code_bits   (act_code_ff[g]),
                .code_length (lengths_ff[g][`LEN_ACT_HI:`LEN_ACT_LO]),
                .bit_en      (det_bit_en[g]),
                .rx_data     (det_data[g]),
                .present_ff  (act_present[g]),
                .held_ff     (act_held[g])
            );

            code_det #(
                .HOLD_CYCLES (HOLD_CYCLES)
            ) u_deact (
                .pclk        (pclk),
                .presetn     (presetn),
                .code_bits   (deact_code_ff[g]),
                .code_length (lengths_ff[g][`LEN_DEACT_HI:`LEN_DEACT_LO]),
                .bit_en      (det_bit_en[g]),
                .rx_data     (det_data[g]),
                .present_ff  (deact_present[g]),
                .held_ff     (deact_held[g])
            );

            // automatic loopback follows the held detections
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    loopback_active_ff[g] <= 1'b0;
                end else if (!control_ff[g][`CTL_AUTO_LOOP]) begin
                    loopback_active_ff[g] <= 1'b0;
                end else if (!loopback_active_ff[g] && act_held[g]) begin
                    loopback_active_ff[g] <= 1'b1;
                end else if (loopback_active_ff[g] && deact_held[g]) begin
                    loopback_active_ff[g] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule // pattern_loop_regs

// ### sim/pattern_loop_regs_properties.sv
`timescale 1ns/100ps
module pattern_loop_regs_properties #(
    parameter [29:0] HOLD_CYCLES = 30'd20
) (
    // clock and reset
    input wire        pclk,
    input wire        presetn,
    // apb
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [12:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // line side
    input wire [16:0] gen_bit_en,
    input wire [16:0] det_bit_en,
    input wire [16:0] det_data,
    input wire [16:0] gen_data,
    input wire [16:0] loopback_active_ff
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // cycles since loopback state last moved
    reg [30:0] quiet_ff;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            quiet_ff <= 31'h0;
        else if ($changed(loopback_active_ff))
            quiet_ff <= 31'h0;
        else if (~&quiet_ff)
            quiet_ff <= quiet_ff + 31'h1;
    end

    a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("pready not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_err_quiet: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response malformed");
    a_rdata_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
        else $error("read data outside read completion");
    a_len_reserved: assert property (pready && !pwrite && paddr[7:2] == 6'h15 |-> prdata[31:6] == 26'h0)
        else $error("length register reserved bits set");
    a_byte_width: assert property (pready && !pwrite && paddr[7:2] >= 6'h12 && paddr[7:2] <= 6'h18
        |-> prdata[31:8] == 24'h0)
        else $error("byte register wider than 8 bits");
    a_gen_cause: assert property ($changed(gen_data) |->
        $past(|gen_bit_en) || $past(pready) || $past(pready, 2))
        else $error("generated bit moved without a strobe");
    a_loop_hold: assert property ($changed(loopback_active_ff) |-> quiet_ff >= HOLD_CYCLES)
        else $error("loopback changed too soon");

    c_write: cover property (pready && pwrite);
    c_error: cover property (pslverr);
    c_loop_on: cover property ($rose(|loopback_active_ff));
endmodule // pattern_loop_regs_properties

bind pattern_loop_regs pattern_loop_regs_properties #(.HOLD_CYCLES(HOLD_CYCLES)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gen_bit_en(gen_bit_en), .det_bit_en(det_bit_en), .det_data(det_data),
    .gen_data(gen_data), .loopback_active_ff(loopback_active_ff));

// ### sim/pattern_loop_regs_tb.sv
`timescale 1ns/100ps
module pattern_loop_regs_tb;
    reg         pclk = 1'b0;
    reg         presetn = 1'b0;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [12:0] paddr = 13'h0;
    reg  [31:0] pwdata = 32'h0;
    reg  [16:0] gen_bit_en = 17'h0;
    reg  [16:0] det_bit_en = 17'h0;
    reg  [16:0] det_data = 17'h0;
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    wire [16:0] gen_data;
    wire [16:0] loopback_active_ff;
    integer     errors = 0;
    integer     num_checks = 0;
    reg  [7:0]  mdl [int];
    reg  [31:0] rd;
    reg         err;
    reg  [7:0]  code;
    reg  [14:0] lfsr;
    reg  [23:0] exp_bits;
    int         ch, off, len, q[$];
    reg  [7:0]  rst_tab [7] = '{8'h55, 8'h55, 8'h55, 8'h01, 8'h01, 8'h01, 8'h09};

    pattern_loop_regs #(.HOLD_CYCLES(30'd20)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .gen_bit_en(gen_bit_en), .det_bit_en(det_bit_en), .det_data(det_data),
        .gen_data(gen_data), .loopback_active_ff(loopback_active_ff));

    always #4 pclk = ~pclk;

    function automatic [10:0] idx(input int c, input int o);
        idx = (c == 0) ? 11'(11'h7c0 + o) : 11'(11'h040 * (c - 1) + o);
    endfunction

    function automatic [7:0] mask(input [10:0] i);
        case (i[5:0])
            6'h15: mask = 8'h3f;
            6'h1f: mask = 8'h07;
            default: mask = 8'hff;
        endcase
    endfunction

    task chk_reg(input [31:0] got, input [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task chk_bit(input got, input exp, input string what);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task apb(input bit wr, input [10:0] i, input [7:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {i, 2'($urandom())};
        pwdata <= {24'($urandom()), wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            errors++;
            $display("wrong value at %0t: no pready", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input [10:0] i, input [7:0] d);
        apb(1'b1, i, d);
        mdl[i] = d & mask(i);
    endtask

    task rdchk(input [10:0] i, input [7:0] e);
        apb(1'b0, i, 8'h00);
        chk_reg(rd, {24'h0, e}, "register read");
    endtask

    // one strobe per bit, sampled once the strobe's edge has landed
    task gen_bits(input int c, input [23:0] pat, input int l, input int nb);
        for (int i = 0; i < nb; i++) begin
            @(posedge pclk);
            gen_bit_en[c] <= 1'b1;
            @(posedge pclk);
            gen_bit_en[c] <= 1'b0;
            @(posedge pclk);
            chk_bit(gen_data[c], pat[l - 1 - (i % l)], "generated bit");
        end
    endtask

    // code sent on channel 3, bit 0 of each repetition last
    task feed(input [7:0] c, input int l, input int nb);
        for (int i = 0; i < nb; i++) begin
            @(posedge pclk);
            det_bit_en[3] <= 1'b1;
            det_data[3] <= c[l - 1 - (i % l)];
        end
        @(posedge pclk);
        det_bit_en[3] <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    task wrap_up;
        $display("checks %0d, mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #200000;
        errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        wrap_up;
    end

    initial begin
        void'($urandom(32'h8c80));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (ch = 1; ch <= 16; ch++)
            for (off = 0; off < 7; off++)
                rdchk(idx(ch, 18 + off), rst_tab[off]);
        rdchk(idx(0, 8'h13), 8'h55);
        rdchk(idx(0, 8'h18), 8'h09);
        $display("reset values done");
        repeat (40) begin
            ch = $urandom_range(16, 1);
            off = $urandom_range(7, 0);
            q.push_back(idx(ch, (off == 7) ? 31 : 18 + off));
            wr(q[$], 8'($urandom()));
        end
        foreach (q[k])
            rdchk(q[k], mdl[q[k]]);
        foreach (rst_tab[k]) begin
            apb(1'b1, (k < 2) ? 11'(11'h7d2 + 3 * k) : (k == 2) ? 11'h412 : 11'h01e, 8'hff);
            chk_bit(err, (k < 3) ? 1'b1 : 1'b0, "error response");
        end
        $display("register access done");
        for (off = 0; off < 3; off++)
            wr(idx(5, 18 + off), 8'($urandom()));
        wr(idx(5, 31), 8'h00);
        wr(idx(5, 31), 8'h02);
        gen_bits(5, {mdl[idx(5, 20)], mdl[idx(5, 19)], mdl[idx(5, 18)]}, 24, 30);
        $display("arbitrary pattern done");
        // channel 9 never strobed so far: its sequence still starts from the all-ones seed
        wr(idx(9, 31), 8'h01);
        lfsr = 15'h7fff;
        for (int i = 23; i >= 0; i--) begin
            exp_bits[i] = lfsr[14];
            lfsr = {lfsr[13:0], lfsr[14] ^ lfsr[13]};
        end
        gen_bits(9, exp_bits, 24, 24);
        wr(idx(9, 31), 8'h00);
        gen_bits(9, 24'h0, 24, 3);
        $display("pseudo-random and off done");
        for (len = 0; len < 4; len++) begin
            wr(idx(7, 21), 8'(len * 16));
            wr(idx(7, 22), 8'($urandom()));
            wr(idx(7, 31), 8'h00);
            wr(idx(7, 31), 8'h03);
            gen_bits(7, {16'h0, mdl[idx(7, 22)]}, len + 5, 2 * (len + 5) + 1);
        end
        $display("code generation done");
        wr(idx(3, 31), 8'h04);
        wr(idx(3, 24), 8'h09);
        for (len = 0; len < 4; len++) begin
            code = 8'($urandom()) | 8'h03;
            wr(idx(3, 21), 8'(len * 4 + 1));
            wr(idx(3, 23), code);
            feed(code, len + 5, 60);
            chk_bit(loopback_active_ff[3], 1'b1, "loopback on");
            feed(8'h09, 6, 60);
            chk_bit(loopback_active_ff[3], 1'b0, "loopback off");
        end
        $display("automatic loopback done");
        wrap_up;
    end
endmodule // pattern_loop_regs_tb
